// [shared/tmoc_pkg.sv]
// Constants, register map and carrier types of the timer output control block
// What this block does
// - Nonzero modes update output on timer rising edge
// - Mode 0 output follows software output bit
// - Mode 1 sets output on channel match
// - Mode 2 toggles, period resets, both sets
// - Mode 3 sets, period resets, both sets
// - Mode 4 toggles on channel match only
// - Mode 5 resets output on channel match
// - Mode 6 toggles, period sets, both resets
// - Mode 7 resets, period sets, both resets
// - Sample matches while clock low, latch rising
// - Up mode uses delayed period match
// - Up/down responds to matches both directions
// - Registers are sixteen bit, word access only
// - Timer control clears on power-up reset only
// - Overflow flag sets on wrap per mode
// - Counter clear resets counter and divider, self-clears
// - Count mode selects stop, up, continuous, up/down
// - Divider field selects divide by 1,2,4,8
// - Clock source field selects one of four clocks
// - Channel control clears on power-up reset only
// - Period match is greater-or-equal, others equality
// - Output mode field sits at bits 5 to 7
package tmoc_pkg;
  localparam int unsigned TMOC_AW = 9;
  localparam logic [8:0] TMOC_ADDR_CTL = 9'h160;
  localparam logic [8:0] TMOC_ADDR_CC0 = 9'h162;
  localparam logic [8:0] TMOC_ADDR_CC1 = 9'h164;
  localparam logic [8:0] TMOC_ADDR_CC2 = 9'h166;
  localparam logic [8:0] TMOC_ADDR_CNT = 9'h170;
  localparam logic [8:0] TMOC_ADDR_CV0 = 9'h172;
  localparam logic [8:0] TMOC_ADDR_CV1 = 9'h174;
  localparam logic [8:0] TMOC_ADDR_CV2 = 9'h176;
  localparam logic [15:0] TMOC_RESET_WORD = 16'h0000;
  localparam logic [15:0] TMOC_MAX_COUNT = 16'hFFFF;
  localparam logic [15:0] TMOC_ZERO_COUNT = 16'h0000;
  // Timer control fields
  localparam int unsigned TMOC_CTL_OVF = 0;
  localparam int unsigned TMOC_CTL_IE = 1;
  localparam int unsigned TMOC_CTL_CLR = 2;
  localparam int unsigned TMOC_CTL_MC = 4;
  localparam int unsigned TMOC_CTL_ID = 6;
  localparam int unsigned TMOC_CTL_SS = 8;
  localparam logic [15:0] TMOC_CTL_WMASK = 16'h03F3;
  // Channel control fields
  localparam int unsigned TMOC_CC_OUT = 2;
  localparam int unsigned TMOC_CC_OM = 5;
  localparam logic [15:0] TMOC_CC_WMASK = 16'hFDFF;
  localparam logic [2:0] TMOC_DIV_MAX = 3'h7;

  typedef enum logic [1:0] {
    TMOC_MC_STOP = 2'b00,
    TMOC_MC_UP = 2'b01,
    TMOC_MC_CONT = 2'b10,
    TMOC_MC_UPDN = 2'b11
  } tmoc_mode_t;

  typedef enum logic [2:0] {
    TMOC_OM_OUT = 3'b000,
    TMOC_OM_SET = 3'b001,
    TMOC_OM_TGLRST = 3'b010,
    TMOC_OM_SETRST = 3'b011,
    TMOC_OM_TGL = 3'b100,
    TMOC_OM_RST = 3'b101,
    TMOC_OM_TGLSET = 3'b110,
    TMOC_OM_RSTSET = 3'b111
  } tmoc_omode_t;

  // Processor side register access
  typedef struct packed {
    logic sel;
    logic wr;
    logic [8:0] addr;
    logic [15:0] wdata;
  } tmoc_bus_t;

  // Four selectable timer clock inputs
  typedef struct packed {
    logic external_timer_clock;
    logic aux_clock;
    logic subsystem_clock;
    logic second_input_clock;
  } tmoc_clk_t;
endpackage

// [design/tmoc_timer.sv]
// Timer counter, register map and three channel output units
`timescale 1ns/1ps
module tmoc_timer #(
  parameter int unsigned CHANNELS = 3
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire tmoc_pkg::tmoc_bus_t bus,
  output logic [15:0] rdata,
  input wire tmoc_pkg::tmoc_clk_t clk_src,
  output logic [2:0] channel_output,
  output logic overflow_irq
);
  import tmoc_pkg::*;

  initial begin
    if (CHANNELS != 3) begin
      $error("tmoc_timer serves exactly three channels");
    end
  end

  typedef struct packed {
    logic [15:0] ctl;
    logic [2:0][15:0] cc;
    logic [2:0][15:0] cv;
    logic [15:0] cnt;
    logic down;
    logic [2:0] div;
    logic [2:0] src_sync;
    logic [2:0] src_sync2;
    logic [2:0] src_sync3;
    logic tclk;
    logic [2:0] eq_smp;
    logic per_smp;
    logic [2:0] out;
    logic [15:0] rd;
  } tmoc_state_t;

  tmoc_state_t st_reg;
  tmoc_state_t st_next;

  tmoc_mode_t mode;
  logic [1:0] ss;
  logic [1:0] idsel;
  logic src_raw;
  logic tclk_f;
  logic tick;
  logic wr_ctl;
  logic wr_cnt;
  logic clr_req;

  // Next output value for one channel, per mode table
  function automatic logic out_next(input logic [2:0] om, input logic q,
                                    input logic eqx, input logic eq0,
                                    input logic swbit);
    logic d;
    d = q;
    case (tmoc_omode_t'(om))
      TMOC_OM_OUT: d = swbit;
      TMOC_OM_SET: d = eqx ? 1'b1 : q;
      TMOC_OM_TGLRST: d = (eq0 & eqx) ? 1'b1 : eq0 ? 1'b0 :
                          eqx ? ~q : q;
      TMOC_OM_SETRST: d = eqx ? 1'b1 : eq0 ? 1'b0 : q;
      TMOC_OM_TGL: d = eqx ? ~q : q;
      TMOC_OM_RST: d = eqx ? 1'b0 : q;
      TMOC_OM_TGLSET: d = (eq0 & eqx) ? 1'b0 : eq0 ? 1'b1 :
                          eqx ? ~q : q;
      TMOC_OM_RSTSET: d = eqx ? 1'b0 : eq0 ? 1'b1 : q;
      default: d = q;
    endcase
    return d;
  endfunction

  // Divider terminal count for a divider field
  function automatic logic [2:0] div_last(input logic [1:0] sel);
    return 3'((4'h1 << sel) - 4'h1);
  endfunction

  assign mode = tmoc_mode_t'(st_reg.ctl[TMOC_CTL_MC +: 2]);
  assign ss = st_reg.ctl[TMOC_CTL_SS +: 2];
  assign idsel = st_reg.ctl[TMOC_CTL_ID +: 2];
  assign wr_ctl = bus.sel & bus.wr & (bus.addr == TMOC_ADDR_CTL);
  assign wr_cnt = bus.sel & bus.wr & (bus.addr == TMOC_ADDR_CNT);
  assign clr_req = wr_ctl & bus.wdata[TMOC_CTL_CLR];

  // Clock source select
  always_comb begin
    case (ss)
      2'b00: src_raw = clk_src.external_timer_clock;
      2'b01: src_raw = clk_src.aux_clock;
      2'b10: src_raw = clk_src.subsystem_clock;
      default: src_raw = clk_src.second_input_clock;
    endcase
  end

  // Filtered source level: second and third stages agree
  assign tclk_f = (st_reg.src_sync2 == st_reg.src_sync3) ?
                  st_reg.src_sync2[0] : st_reg.tclk;

  // Counter advances on a divided rising edge
  assign tick = tclk_f & ~st_reg.tclk & (mode != TMOC_MC_STOP) &&
                (st_reg.div == div_last(idsel));

  always_comb begin
    logic [2:0] eqv;
    logic eq0;
    logic rise;
    logic ovf;
    logic [8:0] ra;
    eqv = '0;
    eq0 = 1'b0;
    ovf = 1'b0;
    ra = bus.addr;
    st_next = st_reg;
    rise = tclk_f & ~st_reg.tclk;

    // Three-stage sampling of the selected clock
    st_next.src_sync = {2'b00, src_raw};
    st_next.src_sync2 = st_reg.src_sync;
    st_next.src_sync3 = st_reg.src_sync2;
    st_next.tclk = tclk_f;

    // Divider runs on source rising edges
    if (rise && mode != TMOC_MC_STOP) begin
      st_next.div = (st_reg.div >= div_last(idsel)) ? 3'h0 :
                    st_reg.div + 3'h1;
    end

    // Counter per count mode
    if (tick) begin
      case (mode)
        TMOC_MC_UP: begin
          if (st_reg.cnt >= st_reg.cv[0]) begin
            st_next.cnt = TMOC_ZERO_COUNT;
            ovf = 1'b1;
          end else begin
            st_next.cnt = st_reg.cnt + 16'h0001;
          end
        end
        TMOC_MC_CONT: begin
          st_next.cnt = st_reg.cnt + 16'h0001;
          ovf = (st_reg.cnt == TMOC_MAX_COUNT);
        end
        TMOC_MC_UPDN: begin
          if (st_reg.down) begin
            st_next.cnt = st_reg.cnt - 16'h0001;
            if (st_reg.cnt == 16'h0001) begin
              st_next.down = 1'b0;
              ovf = 1'b1;
            end
          end else if (st_reg.cnt >= st_reg.cv[0]) begin
            st_next.cnt = st_reg.cnt - 16'h0001;
            st_next.down = 1'b1;
          end else begin
            st_next.cnt = st_reg.cnt + 16'h0001;
          end
        end
        default: st_next.cnt = st_reg.cnt;
      endcase
    end

    // Matches sampled while the timer clock is low
    if (!tclk_f) begin
      for (int i = 0; i < 3; i++) begin
        eqv[i] = (i == 0) ? (st_reg.cnt >= st_reg.cv[0]) :
                 (st_reg.cnt == st_reg.cv[i]);
      end
      // Up mode takes the delayed period match at zero
      eq0 = (mode == TMOC_MC_UP) ? (st_reg.cnt == TMOC_ZERO_COUNT) :
            eqv[0];
      st_next.eq_smp = eqv;
      st_next.per_smp = eq0;
    end

    // Outputs: mode 0 next cycle, others on timer rising edge
    for (int i = 0; i < 3; i++) begin
      // Mode field is the three bits from TMOC_CC_OM up
      if (st_reg.cc[i][TMOC_CC_OM +: 3] == TMOC_OM_OUT) begin
        st_next.out[i] = st_reg.cc[i][TMOC_CC_OUT];
      end else if (rise) begin
        st_next.out[i] = out_next(st_reg.cc[i][TMOC_CC_OM +: 3],
                                  st_reg.out[i], st_reg.eq_smp[i],
                                  st_reg.per_smp,
                                  st_reg.cc[i][TMOC_CC_OUT]);
      end
    end

    // Register writes, whole words only
    if (bus.sel && bus.wr) begin
      case (ra)
        TMOC_ADDR_CTL: st_next.ctl = bus.wdata & TMOC_CTL_WMASK &
                                     ~(16'h0001 << TMOC_CTL_CLR);
        TMOC_ADDR_CC0: st_next.cc[0] = bus.wdata & TMOC_CC_WMASK;
        TMOC_ADDR_CC1: st_next.cc[1] = bus.wdata & TMOC_CC_WMASK;
        TMOC_ADDR_CC2: st_next.cc[2] = bus.wdata & TMOC_CC_WMASK;
        TMOC_ADDR_CNT: st_next.cnt = bus.wdata;
        TMOC_ADDR_CV0: st_next.cv[0] = bus.wdata;
        TMOC_ADDR_CV1: st_next.cv[1] = bus.wdata;
        TMOC_ADDR_CV2: st_next.cv[2] = bus.wdata;
        default: st_next.ctl = st_next.ctl;
      endcase
    end

    // Clear resets counter, divider and direction
    if (clr_req) begin
      st_next.cnt = TMOC_ZERO_COUNT;
      st_next.div = 3'h0;
      st_next.down = 1'b0;
    end

    // Hardware set wins over a software clear of the flag unless the counter is written or cleared
    if (ovf && !wr_cnt && !clr_req) begin
      st_next.ctl[TMOC_CTL_OVF] = 1'b1;
    end

    // Read data registered, unmapped reads zero
    case (ra)
      TMOC_ADDR_CTL: st_next.rd = st_reg.ctl;
      TMOC_ADDR_CC0: st_next.rd = st_reg.cc[0];
      TMOC_ADDR_CC1: st_next.rd = st_reg.cc[1];
      TMOC_ADDR_CC2: st_next.rd = st_reg.cc[2];
      TMOC_ADDR_CNT: st_next.rd = st_reg.cnt;
      TMOC_ADDR_CV0: st_next.rd = st_reg.cv[0];
      TMOC_ADDR_CV1: st_next.rd = st_reg.cv[1];
      TMOC_ADDR_CV2: st_next.rd = st_reg.cv[2];
      default: st_next.rd = TMOC_RESET_WORD;
    endcase
  end

  // Only power-up reset clears control words
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rd;
  assign channel_output = st_reg.out;
  assign overflow_irq = st_reg.ctl[TMOC_CTL_OVF] & st_reg.ctl[TMOC_CTL_IE];

  // Mode 0 output follows the software bit next cycle
  chk_mode0_follows: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_reg.cc[1][TMOC_CC_OM +: 3] == TMOC_OM_OUT) |=>
      (channel_output[1] == $past(st_reg.cc[1][TMOC_CC_OUT])))
    else $error("mode 0 output does not follow bit");

  // Non-zero modes change only on a timer rising edge
  chk_out_edge: assert property (@(posedge mclk) disable iff (!reset_n)
    ($past(st_reg.cc[2][TMOC_CC_OM +: 3]) != TMOC_OM_OUT &&
     $changed(channel_output[2])) |-> $past(tclk_f & ~st_reg.tclk))
    else $error("output changed off timer edge");

  // Set mode with a sampled match drives high
  chk_set_mode: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_reg.cc[1][TMOC_CC_OM +: 3] == TMOC_OM_SET && tclk_f &&
     !st_reg.tclk && st_reg.eq_smp[1]) |=> channel_output[1])
    else $error("set mode missed match");

  // Reset mode with a sampled match drives low
  chk_reset_mode: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_reg.cc[2][TMOC_CC_OM +: 3] == TMOC_OM_RST && tclk_f &&
     !st_reg.tclk && st_reg.eq_smp[2]) |=> !channel_output[2])
    else $error("reset mode missed match");

  // Toggle mode flips the output on a match
  chk_toggle_mode: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_reg.cc[1][TMOC_CC_OM +: 3] == TMOC_OM_TGL && tclk_f &&
     !st_reg.tclk && st_reg.eq_smp[1]) |=>
      (channel_output[1] != $past(channel_output[1])))
    else $error("toggle mode did not toggle");

  // Both matches in mode 2 give a high output
  chk_tglrst_both: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_reg.cc[1][TMOC_CC_OM +: 3] == TMOC_OM_TGLRST && tclk_f &&
     !st_reg.tclk && st_reg.eq_smp[1] && st_reg.per_smp) |=>
      channel_output[1])
    else $error("mode 2 both matches not set");

  // Both matches in mode 6 give a low output
  chk_tglset_both: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_reg.cc[2][TMOC_CC_OM +: 3] == TMOC_OM_TGLSET && tclk_f &&
     !st_reg.tclk && st_reg.eq_smp[2] && st_reg.per_smp) |=>
      !channel_output[2])
    else $error("mode 6 both matches not reset");

  // Clear bit never reads back as one
  chk_clear_reads0: assert property (@(posedge mclk) disable iff (!reset_n)
    clr_req |=> (st_reg.cnt == TMOC_ZERO_COUNT) && !st_reg.ctl[TMOC_CTL_CLR])
    else $error("clear did not reset counter");

  // Continuous wrap sets the overflow flag
  chk_cont_wrap: assert property (@(posedge mclk) disable iff (!reset_n)
    (tick && mode == TMOC_MC_CONT && st_reg.cnt == TMOC_MAX_COUNT &&
     !bus.sel) |=> st_reg.ctl[TMOC_CTL_OVF])
    else $error("wrap did not set overflow");
endmodule

// [tb/tmoc_pin_model.sv]
// Far-side pin load that counts transitions on channel 1
`timescale 1ns/1ps
module tmoc_pin_model (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [2:0] channel_output,
  output logic [15:0] edges_1
);
  logic last_reg;
  // Every level change is counted, so a stray glitch shows up
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      last_reg <= 1'b0;
      edges_1 <= 16'h0000;
    end else begin
      last_reg <= channel_output[1];
      if (channel_output[1] != last_reg) begin
        edges_1 <= edges_1 + 16'h0001;
      end
    end
  end
endmodule

// [tb/test_timer_output_control.sv]
// Self-checking bench for the timer output control block
`timescale 1ns/1ps
module test_timer_output_control;
  import tmoc_pkg::*;
  typedef struct packed {
    logic [8:0] addr;
    logic [15:0] wdata;
    logic [15:0] exp;
  } tmoc_row_t;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  tmoc_bus_t bus = '0;
  logic [3:0] src = 4'h0;
  logic [15:0] rdata;
  logic [2:0] channel_output;
  logic overflow_irq;
  logic [15:0] edges_1;
  logic [15:0] rd;
  logic [15:0] cnt;
  logic [15:0] exp_edges;
  logic ref_out;
  logic nx;
  logic down;
  int num_errors = 0;
  int n_tests = 0;
  // Write value beside its expected readback; last two are unmapped
  tmoc_row_t rows [10] = '{
    '{TMOC_ADDR_CNT, 16'h1234, 16'h1234},
    '{TMOC_ADDR_CC0, 16'hFFFF, 16'hFDFF},
    '{TMOC_ADDR_CC1, 16'hFFFF, 16'hFDFF},
    '{TMOC_ADDR_CC2, 16'hFFFF, 16'hFDFF},
    '{TMOC_ADDR_CV0, 16'hABCD, 16'hABCD},
    '{TMOC_ADDR_CV1, 16'h5A5A, 16'h5A5A},
    '{TMOC_ADDR_CV2, 16'hA5A5, 16'hA5A5},
    '{TMOC_ADDR_CTL, 16'hFFFF, 16'h03F3},
    '{9'h168, 16'hFFFF, 16'h0000},
    '{9'h17E, 16'hFFFF, 16'h0000}};

  // Free-running 25 MHz system clock
  always #20 mclk = ~mclk;

  tmoc_timer #(.CHANNELS(3)) u_dut (
    .mclk(mclk),
    .reset_n(reset_n),
    .bus(bus),
    .rdata(rdata),
    .clk_src(tmoc_clk_t'(src)),
    .channel_output(channel_output),
    .overflow_irq(overflow_irq)
  );

  tmoc_pin_model u_pins (
    .mclk(mclk),
    .reset_n(reset_n),
    .channel_output(channel_output),
    .edges_1(edges_1)
  );

  // Compare helpers, one per result kind
  task automatic chk_word(input string nm, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pin(input string nm, input logic e, g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask

  // One-cycle word accesses; address held until rdata is taken
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge mclk) #1;
    bus = '{1'b1, 1'b1, a, d};
    @(posedge mclk) #1;
    bus.sel = 1'b0;
  endtask
  task automatic rd_reg(input logic [8:0] a, output logic [15:0] d);
    @(posedge mclk) #1;
    bus = '{1'b1, 1'b0, a, 16'h0000};
    @(posedge mclk) #1;
    bus.sel = 1'b0;
    d = rdata;
  endtask

  // One source period, long enough for the 3-flop synchroniser
  task automatic tick(input int s);
    @(posedge mclk) #1;
    src[3 - s] = 1'b1;
    repeat (4) @(posedge mclk);
    #1 src[3 - s] = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
  endtask

  // Output mode table: next level from old level and the two matches
  function automatic logic nxt(input int m, input logic o, e0, ex);
    case (m)
      1: return ex | o;
      2: return e0 ? ex : o ^ ex;
      3: return ex | (o & !e0);
      4: return o ^ ex;
      5: return o & !ex;
      6: return e0 ? !ex : o ^ ex;
      default: return !ex & (o | e0);
    endcase
  endfunction

  // Reference counter, period value 4, up or up/down
  task automatic step(input logic ud);
    if (!ud) cnt = (cnt >= 16'h0004) ? 16'h0000 : cnt + 16'h0001;
    else if (!down && cnt >= 16'h0004) begin
      down = 1'b1;
      cnt = cnt - 16'h0001;
    end else if (down && cnt == 16'h0000) begin
      down = 1'b0;
      cnt = 16'h0001;
    end else cnt = down ? cnt - 16'h0001 : cnt + 16'h0001;
  endtask

  task automatic give_verdict;
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Hang guard, far beyond the expected few thousand cycles
  initial begin
    #2000000;
    num_errors++;
    give_verdict();
  end

  // Main sequence: table rows first, then hand-written cases
  initial begin
    repeat (12) @(posedge mclk);
    #1 reset_n = 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd_reg(rows[i].addr, rd);
      chk_word("readback", rows[i].exp, rd);
    end
    @(posedge mclk) #1 reset_n = 1'b0;
    @(posedge mclk) #1 reset_n = 1'b1;
    for (int a = 0; a < 4; a++) begin
      rd_reg(TMOC_ADDR_CTL + 9'(2 * a), rd);
      chk_word("control after reset", 16'h0000, rd);
    end
    chk_word("pins after reset", 16'h0000, {12'h000, overflow_irq,
      channel_output});
    wr(TMOC_ADDR_CC2, 16'h0004);
    @(posedge mclk) #1;
    chk_pin("mode 0 output", 1'b1, channel_output[2]);
    wr(TMOC_ADDR_CV0, 16'h0004);
    wr(TMOC_ADDR_CV1, 16'h0002);
    exp_edges = 16'h0000;
    ref_out = 1'b0;
    // Output modes 1 to 7 on channel 1, up then up/down counting
    for (int u = 0; u < 2; u++) begin
      for (int m = 1; m < 8; m++) begin
        wr(TMOC_ADDR_CTL, 16'h0204);
        wr(TMOC_ADDR_CC1, 16'h0000);
        exp_edges += 16'(ref_out);
        wr(TMOC_ADDR_CC1, 16'(m << 5));
        wr(TMOC_ADDR_CTL, (u == 1) ? 16'h0230 : 16'h0210);
        cnt = 16'h0000;
        down = 1'b0;
        ref_out = 1'b0;
        repeat (12) begin
          tick(2);
          nx = nxt(m, ref_out, (u == 1) ? cnt >= 16'h0004 :
            cnt == 16'h0000, cnt == 16'h0002);
          exp_edges += 16'(nx != ref_out);
          ref_out = nx;
          step(u == 1);
          chk_pin("channel output", ref_out, channel_output[1]);
        end
        rd_reg(TMOC_ADDR_CNT, rd);
        chk_word("count", cnt, rd);
      end
    end
    chk_word("pin edges", exp_edges, edges_1);
    // Overflow on continuous wrap, then cleared by software
    wr(TMOC_ADDR_CTL, 16'h0202);
    wr(TMOC_ADDR_CNT, 16'hFFFE);
    wr(TMOC_ADDR_CTL, 16'h0222);
    tick(2);
    chk_pin("overflow early", 1'b0, overflow_irq);
    tick(2);
    chk_pin("overflow at wrap", 1'b1, overflow_irq);
    wr(TMOC_ADDR_CTL, 16'h0202);
    repeat (2) @(posedge mclk);
    #1;
    chk_pin("overflow cleared", 1'b0, overflow_irq);
    // Divider settings, each from a cleared counter
    for (int d = 0; d < 4; d++) begin
      wr(TMOC_ADDR_CTL, 16'(32'h0204 | d << 6));
      wr(TMOC_ADDR_CTL, 16'(32'h0220 | d << 6));
      repeat (8) tick(2);
      rd_reg(TMOC_ADDR_CNT, rd);
      chk_word("divided count", 16'(8 >> d), rd);
    end
    // Each source alone advances; a neighbour's edges are ignored
    for (int s = 0; s < 4; s++) begin
      wr(TMOC_ADDR_CTL, 16'(s << 8 | 4));
      wr(TMOC_ADDR_CTL, 16'(s << 8 | 32));
      repeat (3) tick(s);
      tick((s + 1) % 4);
      rd_reg(TMOC_ADDR_CNT, rd);
      chk_word("source count", 16'h0003, rd);
    end
    wr(TMOC_ADDR_CTL, 16'h0300);
    repeat (2) tick(3);
    rd_reg(TMOC_ADDR_CNT, rd);
    chk_word("stopped count", 16'h0003, rd);
    give_verdict();
  end
endmodule
